// ===== hw/scope_sample_rate_reducer.sv
// scope rate reduction top: sync, apb registers, capture memory
// Functional notes
// - take one converter sample every clock at the full rate, any setting.
// - divide by N records one sample per N, averaged or one kept.
// - min/max mode stores the minimum and maximum of every 2N samples.
// - min/max stores entries at half the rate of the other modes.
// - reduction runs live in logic ahead of the capture memory.
// - capture depth is 8k records per channel by default.
// - an alternate configuration lets the depth reach 16k per channel.
// - scope and digital lines are captured on one shared clock.
// - each analog channel picks its own sampling mode.
//
// Implementation choices: the APB register port and the register offsets.
module scope_sample_rate_reducer
    import ssrr_pkg::*;
(
    // clock and reset
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst_n,

    // apb slave
    input  wire logic                        i_psel,
    input  wire logic                        i_penable,
    input  wire logic                        i_pwrite,
    input  wire logic [APB_AW-1:0]           i_paddr,
    input  wire logic [31:0]                 i_pwdata,
    output logic      [31:0]                 o_prdata,
    output logic                             o_pready,
    output logic                             o_pslverr,

    // converter and digital lines, asynchronous pins
    input  wire logic [CH_N-1:0][ADC_W-1:0]  i_adc_data,
    input  wire logic [DIO_W-1:0]            i_dio,

    // digital lines aligned with the scope samples
    output logic      [DIO_W-1:0]            o_dio_sample
);
    // sized for the larger allocation
    localparam int DEPTH_MAX = 1 << MEM_AW;

    typedef struct packed {
        logic [CH_N-1:0][ADC_W-1:0]   adc_s1;
        logic [CH_N-1:0][ADC_W-1:0]   adc_s2;
        logic [DIO_W-1:0]             dio_s1;
        logic [DIO_W-1:0]             dio_s2;
        logic [DIO_W-1:0]             dio_out;

        logic                         run;
        logic                         big;
        ssrr_mode_t [CH_N-1:0]        mode;
        logic [CH_N-1:0][LOG2N_W-1:0] log2n;
        logic                         restart;

        logic [CH_N-1:0]              full;
        logic [CH_N-1:0]              ovf;
        logic [CH_N-1:0][CNT_W-1:0]   count;

        logic [MEM_AW-1:0]            rd_addr;
        logic                         rd_ch;
        ssrr_rd_t                     rd_state;
        logic [31:0]                  prdata;
    } ssrr_top_t;

    logic [1:0]                rst_pipe;
    logic                      rst_n;
    ssrr_top_t                 r;
    ssrr_top_t                 next_r;

    logic [CH_N-1:0]           red_ovf;
    logic [CH_N-1:0]           buf_valid;
    logic [CH_N-1:0]           buf_ready;
    logic [CH_N-1:0][PAIR_W-1:0] buf_data;
    logic [CH_N-1:0][PAIR_W-1:0] rdq;
    logic [CH_N-1:0]           wr_en;
    logic [CH_N-1:0]           rd_en;

    logic                      setup;
    logic                      access;
    logic                      sel_rddata;
    logic                      mapped;
    logic                      rd_wait;
    logic                      red_run;

    // release of the asynchronous reset is retimed to the clock
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rst_pipe <= 2'b00;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_n = rst_pipe[1];

    assign setup      = i_psel & ~i_penable;
    assign access     = i_psel & i_penable;
    assign sel_rddata = (i_paddr == OFS_RDDATA);
    assign mapped     = (i_paddr == OFS_CTRL) || (i_paddr == OFS_CMD)
                     || (i_paddr == OFS_STATUS) || (i_paddr == OFS_COUNT)
                     || (i_paddr == OFS_RDADDR) || sel_rddata;

    // memory read data lands one cycle late, so one wait state
    assign rd_wait    = access & ~i_pwrite & sel_rddata
                     & (r.rd_state == RD_IDLE);
    assign o_pready   = ~rd_wait;
    assign o_pslverr  = access & ~mapped;

    assign o_prdata   = r.prdata;
    assign o_dio_sample = r.dio_out;

    // restart re-aligns every group
    assign red_run    = r.run & ~r.restart;

    // one reducer, buffer and memory per channel
    genvar c;
    generate
        for (c = 0; c < CH_N; c++)
        begin : g_ch
            ssrr_stream_if #(.WIDTH(PAIR_W)) red_if ();
            ssrr_stream_if #(.WIDTH(PAIR_W)) buf_if ();
            logic [PAIR_W-1:0] mem [DEPTH_MAX];

            // reduction sits in the sample path
            ssrr_reduce u_reduce (
                .i_mclk     (i_mclk),
                .i_rst_n    (rst_n),
                .i_run      (red_run),
                .i_mode     (r.mode[c]),
                .i_log2n    (r.log2n[c]),
                .i_sample   (r.adc_s2[c]),
                .o_out      (red_if.src),
                .o_overflow (red_ovf[c])
            );

            ssrr_fifo2 #(
                .WIDTH (PAIR_W),
                .DEPTH (FIFO_DEPTH)
            ) u_fifo (
                .i_mclk  (i_mclk),
                .i_rst_n (rst_n),
                .i_in    (red_if.snk),
                .o_out   (buf_if.src)
            );

            assign buf_valid[c]  = buf_if.valid;
            assign buf_data[c]   = buf_if.data;
            assign buf_if.ready  = buf_ready[c];

            // single port: a host read steals the cycle from the writer
            assign rd_en[c]      = setup & ~i_pwrite & sel_rddata
                                 & (r.rd_ch == 1'(c));
            assign buf_ready[c]  = ~rd_en[c];
            assign wr_en[c]      = buf_valid[c] & buf_ready[c] & r.run
                                 & ~r.full[c] & ~r.restart;

            // no reset: the array is plain memory
            always_ff @(posedge i_mclk)
            begin
                if (wr_en[c])
                    mem[r.count[c][MEM_AW-1:0]] <= buf_data[c];
                if (rd_en[c])
                    rdq[c] <= mem[r.rd_addr];
            end
        end
    endgenerate

    always_comb
    begin
        logic             done;
        logic             wr_do;
        logic [CNT_W-1:0] depth;
        logic [31:0]      rv;

        done  = access & o_pready;
        wr_do = done & i_pwrite;

        depth = r.big ? DEPTH_ALT : DEPTH_DEF;
        rv    = '0;
        next_r = r;

        // scope and digital lines share clock and sync depth
        next_r.adc_s1  = i_adc_data;
        next_r.adc_s2  = r.adc_s1;
        next_r.dio_s1  = i_dio;
        next_r.dio_s2  = r.dio_s1;
        next_r.dio_out = r.dio_s2;
        next_r.restart = 1'b0;

        for (int k = 0; k < CH_N; k++)
        begin
            // overflow is sticky; a new event beats the clear
            next_r.ovf[k] = (r.ovf[k] & ~(wr_do && i_paddr == OFS_STATUS
                            && i_pwdata[STAT_OVF_LSB + k])) | red_ovf[k];

            if (r.restart)
            begin
                next_r.count[k] = '0;
                next_r.full[k]  = 1'b0;
            end
            else if (wr_en[k])
            begin
                next_r.count[k] = r.count[k] + 1'b1;
                // later records drain and are dropped
                if (r.count[k] + 1'b1 >= depth)
                    next_r.full[k] = 1'b1;
            end
        end

        // register writes take effect at the completing edge
        if (wr_do)
        begin
            case (i_paddr)
                OFS_CTRL:
                begin
                    next_r.run = i_pwdata[CTRL_RUN_BIT];
                    next_r.big = i_pwdata[CTRL_BIG_BIT];
                    for (int k = 0; k < CH_N; k++)
                    begin
                        next_r.mode[k]  = ssrr_mode_t'(
                            i_pwdata[CTRL_MODE_LSB + 2 * k +: 2]);
                        next_r.log2n[k] =
                            i_pwdata[CTRL_LOG2N_LSB + LOG2N_W * k +: LOG2N_W];
                    end
                end
                OFS_CMD:
                    next_r.restart = i_pwdata[CMD_RESTART_BIT];
                OFS_RDADDR:
                begin
                    next_r.rd_addr = i_pwdata[MEM_AW-1:0];
                    next_r.rd_ch   = i_pwdata[RDADDR_CH_BIT];
                end
                default:
                    next_r.rd_ch = r.rd_ch;
            endcase
        end

        // read data is captured in the setup cycle for plain registers
        case (i_paddr)
            OFS_CTRL:
            begin
                rv[CTRL_RUN_BIT] = r.run;
                rv[CTRL_BIG_BIT] = r.big;
                for (int k = 0; k < CH_N; k++)
                begin
                    rv[CTRL_MODE_LSB + 2 * k +: 2] = r.mode[k];
                    rv[CTRL_LOG2N_LSB + LOG2N_W * k +: LOG2N_W] = r.log2n[k];
                end
            end
            OFS_STATUS:
                for (int k = 0; k < CH_N; k++)
                begin
                    rv[STAT_FULL_LSB + k] = r.full[k];
                    rv[STAT_OVF_LSB + k]  = r.ovf[k];
                end
            OFS_COUNT:
                for (int k = 0; k < CH_N; k++)
                    rv[COUNT_STRIDE * k +: CNT_W] = r.count[k];
            OFS_RDADDR:
            begin
                rv[MEM_AW-1:0]    = r.rd_addr;
                rv[RDADDR_CH_BIT] = r.rd_ch;
            end
            // write-only and unmapped offsets read zero
            default:
                rv = '0;
        endcase

        if (setup)
            next_r.prdata = rv;

        case (r.rd_state)
            RD_IDLE:
                if (rd_wait)
                begin
                    next_r.prdata   = {{(32 - PAIR_W){1'b0}}, rdq[r.rd_ch]};
                    next_r.rd_state = RD_HOLD;
                end
            // hold the word until the host takes it
            RD_HOLD:
                if (done)
                    next_r.rd_state = RD_IDLE;
            default:
                next_r.rd_state = RD_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r       <= '0;
            r.run   <= RUN_RST;
            r.big   <= BIG_RST;
            for (int k = 0; k < CH_N; k++)
                r.mode[k] <= MODE_AVG;
            r.log2n <= {CH_N{LOG2N_RST}};
        end
        else
            r <= next_r;
    end
endmodule : scope_sample_rate_reducer

// ===== hw/ssrr_fifo2.sv
// small valid/ready buffer that absorbs capture-memory stalls
module ssrr_fifo2 #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic   i_mclk,
    input  wire logic   i_rst_n,
    // streams
    ssrr_stream_if.snk  i_in,
    ssrr_stream_if.src  o_out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] ent;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } ssrr_fifo_t;

    ssrr_fifo_t r;
    ssrr_fifo_t next_r;
    logic       push;
    logic       pop;

    assign i_in.ready  = (r.cnt != FULL);
    assign o_out.valid = (r.cnt != '0);
    assign o_out.data  = r.ent[r.rp];
    assign push        = i_in.valid & i_in.ready;
    assign pop         = o_out.valid & o_out.ready;

    always_comb
    begin
        next_r = r;
        if (push)
        begin
            next_r.ent[r.wp] = i_in.data;
            next_r.wp        = (r.wp == LAST) ? '0 : r.wp + 1'b1;
        end
        if (pop)
            next_r.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
        if (push & ~pop)
            next_r.cnt = r.cnt + 1'b1;
        else if (pop & ~push)
            next_r.cnt = r.cnt - 1'b1;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            r <= '0;
        else
            r <= next_r;
    end
endmodule : ssrr_fifo2

// ===== hw/ssrr_pkg.sv
// shared constants and types of the scope sample rate reducer
package ssrr_pkg;
    // stream geometry
    localparam int ADC_W      = 14;
    localparam int CH_N       = 2;
    localparam int DIO_W      = 16;
    localparam int PAIR_W     = 2 * ADC_W;
    localparam int LOG2N_W    = 4;
    localparam int GRP_W      = 16;
    localparam int ACC_W      = ADC_W + GRP_W;
    localparam int FIFO_DEPTH = 2;
    // converter rate; every clock edge carries one converter sample
    localparam int SAMPLE_RATE_HZ = 100_000_000;
    // capture depth per channel
    localparam int MEM_AW = 14;
    localparam int CNT_W  = MEM_AW + 1;
    localparam logic [CNT_W-1:0] DEPTH_DEF = 15'h2000;
    localparam logic [CNT_W-1:0] DEPTH_ALT = 15'h4000;
    // apb map, byte addresses
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] OFS_CTRL   = 8'h00;
    localparam logic [APB_AW-1:0] OFS_CMD    = 8'h04;
    localparam logic [APB_AW-1:0] OFS_STATUS = 8'h08;
    localparam logic [APB_AW-1:0] OFS_COUNT  = 8'h0C;
    localparam logic [APB_AW-1:0] OFS_RDADDR = 8'h10;
    localparam logic [APB_AW-1:0] OFS_RDDATA = 8'h14;
    // field positions
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_BIG_BIT   = 1;
    localparam int CTRL_MODE_LSB  = 4;
    localparam int CTRL_LOG2N_LSB = 8;
    localparam int CMD_RESTART_BIT = 0;
    localparam int STAT_FULL_LSB  = 0;
    localparam int STAT_OVF_LSB   = 4;
    localparam int COUNT_STRIDE   = 16;
    localparam int RDADDR_CH_BIT  = 16;
    // values after reset
    localparam logic [LOG2N_W-1:0] LOG2N_RST = 4'h0;
    localparam logic               RUN_RST   = 1'b0;
    localparam logic               BIG_RST   = 1'b0;

    typedef enum logic [1:0] {
        MODE_AVG    = 2'b00,
        MODE_DEC    = 2'b01,
        MODE_MINMAX = 2'b10
    } ssrr_mode_t;

    typedef enum logic {
        RD_IDLE = 1'b0,
        RD_HOLD = 1'b1
    } ssrr_rd_t;
endpackage : ssrr_pkg

// ===== hw/ssrr_reduce.sv
// one channel of real-time averaging, decimation and min/max pairing
module ssrr_reduce
    import ssrr_pkg::*;
(
    // clock and reset
    input  wire logic                     i_mclk,
    input  wire logic                     i_rst_n,
    // configuration
    input  wire logic                     i_run,
    input  ssrr_mode_t                    i_mode,
    input  wire logic [LOG2N_W-1:0]       i_log2n,
    // converter sample, one per clock
    input  wire logic signed [ADC_W-1:0]  i_sample,
    // reduced stream and loss pulse
    ssrr_stream_if.src                    o_out,
    output logic                          o_overflow
);
    typedef struct packed {
        logic [GRP_W-1:0]        cnt;
        logic signed [ACC_W-1:0] acc;
        logic signed [ADC_W-1:0] mn;
        logic signed [ADC_W-1:0] mx;
        logic signed [ADC_W-1:0] kept;
        logic                    vld;
        logic [PAIR_W-1:0]       data;
        logic                    ovf;
    } ssrr_red_t;

    ssrr_red_t r;
    ssrr_red_t next_r;

    assign o_out.valid = r.vld;
    assign o_out.data  = r.data;
    assign o_overflow  = r.ovf;

    always_comb
    begin
        logic                    minmax;
        logic                    first;
        logic [4:0]              shamt;
        logic [GRP_W-1:0]        grp_last;
        logic signed [ACC_W-1:0] acc_in;
        logic signed [ACC_W-1:0] avg;
        logic signed [ADC_W-1:0] mn_in;
        logic signed [ADC_W-1:0] mx_in;
        logic signed [ADC_W-1:0] kept_in;
        minmax   = (i_mode == MODE_MINMAX);
        first    = (r.cnt == '0);
        shamt    = {1'b0, i_log2n} + 5'(minmax);
        grp_last = GRP_W'((17'h00001 << shamt) - 17'h00001);
        acc_in   = first ? ACC_W'(i_sample) : r.acc + ACC_W'(i_sample);
        avg      = acc_in >>> i_log2n;
        mn_in    = (first || i_sample < r.mn) ? i_sample : r.mn;
        mx_in    = (first || i_sample > r.mx) ? i_sample : r.mx;
        kept_in  = first ? i_sample : r.kept;
        next_r     = r;
        next_r.ovf = 1'b0;
        if (o_out.ready)
            next_r.vld = 1'b0;
        if (!i_run)
            next_r.cnt = '0;
        else
        begin
            // one sample taken each clock, never stalled
            next_r.acc  = acc_in;
            next_r.mn   = mn_in;
            next_r.mx   = mx_in;
            next_r.kept = kept_in;
            if (r.cnt == grp_last)
            begin
                next_r.cnt = '0;
                next_r.vld = 1'b1;
                // a held word not yet taken is replaced and reported
                next_r.ovf = r.vld & ~o_out.ready;
                // one record from each group of N, or of 2N for min/max
                // with N of one, average and decimate pass the sample unchanged
                case (i_mode)
                    MODE_AVG:
                        next_r.data = {{ADC_W{1'b0}}, avg[ADC_W-1:0]};
                    // one pair per 2N halves the stored rate
                    MODE_MINMAX:
                        next_r.data = {mx_in, mn_in};
                    default:
                        next_r.data = {{ADC_W{1'b0}}, kept_in};
                endcase
            end
            else
                next_r.cnt = r.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            r <= '0;
        else
            r <= next_r;
    end
endmodule : ssrr_reduce

// ===== hw/ssrr_stream_if.sv
// valid/ready stream carrier between the reducer stages
interface ssrr_stream_if #(
    parameter int WIDTH = 28
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ssrr_stream_if

// ===== tb/scope_sample_rate_reducer_test.sv
// self-checking bench of the scope sample rate reducer
module scope_sample_rate_reducer_test
    import ssrr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                       clk = 1'b0;
    logic                       rst_n = 1'b0;
    logic                       psel = 1'b0;
    logic                       pen = 1'b0;
    logic                       pwr = 1'b0;
    logic                       hold = 1'b1;
    logic [APB_AW-1:0]          paddr = '0;
    logic [31:0]                pwdata = 32'h0;
    logic [31:0]                prdata, rd;
    logic                       pready, pslverr, er;
    logic [CH_N-1:0][ADC_W-1:0] adc;
    logic [DIO_W-1:0]           dio, dio_s;
    logic [27:0]                r0 [4];
    logic [27:0]                r1 [4];
    int                         err_total = 0;
    int                         n_tests = 0;

    always #50 clk = ~clk;

    ssrr_adc_model u_adc (.i_mclk(clk), .i_hold(hold), .o_adc_data(adc),
        .o_dio(dio));
    scope_sample_rate_reducer dut (.i_mclk(clk), .i_rst_n(rst_n),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_adc_data(adc), .i_dio(dio),
        .o_dio_sample(dio_s));

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    begin
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    end
    endtask : chk

    // pready sampled at the rising edge; released just after that edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
    begin
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    end
    endtask : apb

    task automatic rec(input logic ch, input logic [13:0] i);
    begin
        apb(1'b1, OFS_RDADDR, {15'h0, ch, 2'h0, i});
        apb(1'b0, OFS_RDDATA, 32'h0);
    end
    endtask : rec

    task automatic start(input logic [31:0] ctrl);
    begin
        @(posedge clk);
        hold <= 1'b1;
        @(posedge clk);
        hold <= 1'b0;
        apb(1'b1, OFS_CTRL, ctrl);
        apb(1'b1, OFS_STATUS, 32'h30);
        apb(1'b1, OFS_CMD, 32'h1);
    end
    endtask : start

    task automatic t_regs;
    begin
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status reset", 32'h0, rd);
        apb(1'b0, OFS_COUNT, 32'h0);
        chk("count reset", 32'h0, rd);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'h1, er);
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, OFS_CTRL, 32'h0000A650);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl back", 32'h0000A650, rd);
        apb(1'b0, OFS_CMD, 32'h0);
        chk("cmd read", 32'h0, rd);
        $display("t_regs done");
    end
    endtask : t_regs

    // ch0 ramp checked by record steps, ch1 alternates 0x64 and 0x14
    task automatic t_mode(input logic [1:0] m0, input logic [3:0] l0,
                          input logic [1:0] m1, input logic [3:0] l1);
        logic [31:0] n;
    begin
        start({16'h0, l1, l0, m1, m0, 4'h1});
        repeat (80) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            rec(1'b0, 14'(i));
            r0[i] = rd[27:0];
            rec(1'b1, 14'(i));
            r1[i] = rd[27:0];
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("overflow", 32'(l0 == 4'h0), rd[5:4]);
        n = 32'h1 << l0;
        for (int i = 1; i < 3; i++)
        begin
            if (m0 == 2'b10)
            begin
                chk("mm span", 2 * n - 1, r0[i][27:14] - r0[i][13:0]);
                chk("mm step", 2 * n, r0[i + 1][13:0] - r0[i][13:0]);
            end
            else
                chk("step", n, r0[i + 1][13:0] - r0[i][13:0]);
            if (m1 == 2'b00)
                chk("ch1 avg", 32'h3C, r1[i]);
            else if (m1 == 2'b10)
                chk("ch1 pair", {14'h64, 14'h14}, r1[i]);
            else
            begin
                chk("ch1 same", r1[1], r1[i + 1]);
                chk("ch1 kept", 1, r1[i] == 28'h64 || r1[i] == 28'h14);
            end
        end
        $display("t_mode %0d %0d done", m0, m1);
    end
    endtask : t_mode

    task automatic t_rate;
        logic [14:0] c0, c1;
    begin
        start({16'h0, 4'h2, 4'h2, 2'b10, 2'b01, 4'h1});
        repeat (400) @(posedge clk);
        apb(1'b0, OFS_COUNT, 32'h0);
        c0 = rd[14:0];
        c1 = rd[30:16];
        chk("dec count", 1, c0 >= 15'h60 && c0 <= 15'h65);
        chk("mm count", 1, c1 >= 15'h30 && c1 <= 15'h33);
        chk("half rate", 1, c0 + 2 >= 2 * c1 && c0 <= 2 * c1 + 3);
        $display("t_rate done");
    end
    endtask : t_rate

    task automatic t_depth(input logic big, input logic [14:0] depth);
    begin
        start({16'h0, 14'h0, big, 1'b1});
        rd = 32'h0;
        for (int k = 0; k < 80 && rd[1:0] !== 2'b11; k++)
        begin
            repeat (256) @(posedge clk);
            apb(1'b0, OFS_STATUS, 32'h0);
        end
        chk("full flags", 32'h3, rd[1:0]);
        chk("no loss", 32'h0, rd[5:4]);
        apb(1'b0, OFS_COUNT, 32'h0);
        chk("depth", {1'b0, depth, 1'b0, depth}, rd);
        $display("t_depth %0d done", big);
    end
    endtask : t_depth

    task automatic final_report;
    begin
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask : final_report

    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs;
        t_mode(2'b00, 4'h0, 2'b00, 4'h1);
        t_mode(2'b01, 4'h0, 2'b01, 4'h1);
        t_mode(2'b00, 4'h2, 2'b10, 4'h0);
        t_mode(2'b10, 4'h1, 2'b01, 4'h1);
        t_mode(2'b11, 4'h2, 2'b11, 4'h1);
        t_rate;
        t_depth(1'b0, DEPTH_DEF);
        t_depth(1'b1, DEPTH_ALT);
        final_report;
    end

    // run needs about 30k cycles; twice that means a hang
    initial
    begin
        repeat (60000) @(posedge clk);
        err_total++;
        $display("watchdog expired");
        final_report;
    end
endmodule : scope_sample_rate_reducer_test

// ===== tb/ssrr_adc_model.sv
// converter and digital line stimulus model
module ssrr_adc_model
    import ssrr_pkg::*;
(
    // clock and control
    input  wire logic                   i_mclk,
    input  wire logic                   i_hold,
    // converter samples and digital lines
    output logic [CH_N-1:0][ADC_W-1:0]  o_adc_data,
    output logic [DIO_W-1:0]            o_dio
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [11:0] ramp = 12'h000;

    // new sample each clock
    // ramp stays below the 14-bit sign bit, so a short run never wraps
    always @(posedge i_mclk)
    begin
        ramp <= i_hold ? 12'h000 : ramp + 12'h001;
        o_adc_data[0] <= {2'h0, ramp};
        o_adc_data[1] <= ramp[0] ? 14'h0064 : 14'h0014;
        o_dio <= {ramp, ramp[3:0]} ^ 16'hA5C3;
    end
endmodule : ssrr_adc_model

// ===== tb/ssrr_chk_sva.sv
// assertions on the rate reducer top ports
module ssrr_chk
    import ssrr_pkg::*;
(
    // clock, reset, apb
    input wire logic              i_mclk,
    input wire logic              i_rst_n,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [APB_AW-1:0] i_paddr,
    input wire logic [31:0]       o_prdata,
    input wire logic              o_pready,
    input wire logic              o_pslverr,
    // digital lines
    input wire logic [DIO_W-1:0]  i_dio,
    input wire logic [DIO_W-1:0]  o_dio_sample
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    logic [2:0] age;
    wire acc = i_psel && i_penable;
    wire stp = i_psel && !i_penable;
    wire mapd = (i_paddr <= OFS_RDDATA) && (i_paddr[1:0] == 2'h0);
    wire is_rd = (i_paddr == OFS_RDDATA) && !i_pwrite;

    // pipeline needs a few edges after reset before it is meaningful
    always_ff @(posedge i_mclk or negedge i_rst_n)
        if (!i_rst_n)
            age <= 3'h0;
        else if (age != 3'h7)
            age <= age + 3'h1;

    sequence s_rd_setup;
        stp && is_rd ##1 acc;
    endsequence
    sequence s_rd_wait;
        !o_pready ##1 o_pready;
    endsequence

    chk_dio_align: assert property (
        age == 3'h7 |-> o_dio_sample == $past(i_dio, 3))
        else $error("digital sample not aligned");
    chk_err_unmapped: assert property (
        acc && !mapd |-> o_pslverr)
        else $error("unmapped access without error");
    chk_err_mapped: assert property (
        acc && mapd |-> !o_pslverr)
        else $error("mapped access flagged");
    chk_ready_fast: assert property (
        acc && !is_rd |-> o_pready)
        else $error("register access stalled");
    chk_mem_wait: assert property (
        s_rd_setup |-> s_rd_wait)
        else $error("memory read wait wrong");
    chk_data_hold: assert property (
        acc && o_pready |=> $stable(o_prdata))
        else $error("read data changed after transfer");
    chk_zero_read: assert property (
        stp && !i_pwrite && (i_paddr == OFS_CMD || !mapd)
        |=> o_prdata == 32'h0)
        else $error("write-only or unmapped read not zero");
    chk_count_range: assert property (
        stp && !i_pwrite && i_paddr == OFS_COUNT |=>
        o_prdata[14:0] <= DEPTH_ALT && o_prdata[30:16] <= DEPTH_ALT)
        else $error("record count beyond depth");
    chk_rec_width: assert property (
        s_rd_setup ##1 acc |-> o_prdata[31:28] == 4'h0)
        else $error("record word too wide");
endmodule : ssrr_chk

bind scope_sample_rate_reducer ssrr_chk u_chk (.i_mclk, .i_rst_n,
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready,
    .o_pslverr, .i_dio, .o_dio_sample);
